// file: logic/scw_pkg.sv
// shared constants, types and refresh-byte decoding for the challenge watchdog
// assumes a 50 MHz system clock on both ends of the serial link
package scw_pkg;
  localparam int CLK_MHZ = 50;
  localparam int WD_UNIT_US = 2000;
  localparam int WD_UNIT_CYC = WD_UNIT_US * CLK_MHZ;
  localparam int NREQ_TIMEOUT_MS = 256;
  localparam int NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int RESET_HOLD_US = 1000;
  localparam int RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
  localparam logic [3:0] INT_PULSE_CYC = 4'h8;
  localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HALF_FRAME_BITS = 5'h08;
  localparam int CNT_W = 24;
  localparam logic [1:0] BOOT_DONE = 2'h3;

  localparam logic [7:0] CMD_REFRESH = 8'h5A;
  localparam logic [7:0] CMD_READ_CHAL = 8'h1B;
  localparam logic [7:0] CMD_INIT_WD = 8'h21;
  localparam logic [7:0] CMD_TIMER = 8'h23;
  localparam logic [7:0] CMD_INT_READ = 8'h25;
  localparam logic [7:0] CMD_CAN_REG = 8'h27;

  localparam int CFG_WINDOW_BIT = 1;
  localparam int CFG_TYPE_LSB = 2;
  localparam int CFG_INTCHK_BIT = 7;
  localparam int TIM_CODE_MSB = 2;
  localparam int TIM_SHORT_BIT = 7;
  localparam int CAN_EN_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] TIM_RESET = 3'h0;
  // arbitrary nonzero seed
  localparam logic [7:0] CHAL_SEED = 8'hA5;

  typedef enum logic [1:0] {
    WD_SIMPLE = 2'h0,
    WD_ADV1 = 2'h1,
    WD_ADV2 = 2'h2,
    WD_ADV4 = 2'h3
  } scw_wdtype_t;

  typedef enum logic [3:0] {
    MODE_INIT = 4'h1,
    MODE_NREQ = 4'h2,
    MODE_NORMAL = 4'h4,
    MODE_RESET = 4'h8
  } scw_mode_t;

  function automatic logic [1:0] scw_last_part(scw_wdtype_t t);
    case (t)
      WD_ADV2: scw_last_part = 2'h1;
      WD_ADV4: scw_last_part = 2'h3;
      default: scw_last_part = 2'h0;
    endcase
  endfunction : scw_last_part

  // data byte expected in partial refresh idx; msbs go first
  function automatic logic [7:0] scw_part_byte(logic [7:0] chal, scw_wdtype_t t,
                                               logic [1:0] idx);
    logic [7:0] inv;
    inv = ~chal;
    case (t)
      WD_ADV1: scw_part_byte = inv;
      WD_ADV2: scw_part_byte = inv & (idx[0] ? 8'h0F : 8'hF0);
      WD_ADV4: scw_part_byte = inv & (8'hC0 >> {idx, 1'b0});
      default: scw_part_byte = 8'h00;
    endcase
  endfunction : scw_part_byte
endpackage : scw_pkg

// file: logic/scw_if.sv
// serial link between the watchdog device and its host controller
// host drives clock, select and data out; device answers and pulses its interrupt
`timescale 1ns/1ps
interface scw_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic intN;
  modport dev (input sclk, input csN, input mosi, output miso, output intN);
  modport host (output sclk, output csN, output mosi, input miso, input intN);
endinterface : scw_if

// file: logic/scw_device.sv
// device end: serial slave, mode control, watchdog timers and challenge check
// assumes a host sending 16-bit msb-first frames, data valid on sclk rise
`timescale 1ns/1ps
module scw_device
  import scw_pkg::*;
#(
  parameter int WD_UNIT = WD_UNIT_CYC,
  parameter int NREQ_TIMEOUT = NREQ_TIMEOUT_CYC,
  parameter int RESET_HOLD = RESET_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  scw_if.dev spi,
  input wire logic debugSelectPin,
  input wire logic batteryFail,
  input wire logic eventIn,
  output scw_mode_t mode,
  output logic wdResetN,
  output logic canSupplyRegulator,
  output logic [7:0] randomChallengeCode
);
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic [1:0] syncC;
  logic [4:0] bitCnt;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [7:0] nextChal;
  logic [7:0] lfsr;
  logic [7:0] cfg;
  logic [2:0] periodCode;
  logic nreqShort;
  logic [1:0] partIdx;
  logic [CNT_W-1:0] periodCnt;
  logic [CNT_W-1:0] resetHold;
  logic intPending;
  logic [CNT_W-1:0] intAge;
  logic [3:0] intPulseCnt;
  logic intN;
  logic [1:0] bootCnt;

  // link pins and straps pass two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 5'h03;
      syncB <= 5'h03;
      syncC <= 2'h1;
    end else begin
      syncA <= {batteryFail, debugSelectPin, spi.sclk, spi.csN, spi.mosi};
      syncB <= syncA;
      syncC <= syncB[2:1];
    end
  end

  wire logic mosiS = syncB[0];
  wire logic csS = syncB[1];
  wire logic sclkS = syncB[2];
  wire logic dbgS = syncB[3];
  wire logic batS = syncB[4];
  wire logic sclkRise = sclkS & ~syncC[1] & ~csS;
  wire logic sclkFall = ~sclkS & syncC[1] & ~csS;
  wire logic csFall = ~csS & syncC[0];
  wire logic frameDone = csS & ~syncC[0] & (bitCnt == FRAME_BITS);
  wire logic [7:0] cmd = rx[15:8];
  wire logic [7:0] dat = rx[7:0];

  wire scw_wdtype_t wdType = scw_wdtype_t'(cfg[CFG_TYPE_LSB+1:CFG_TYPE_LSB]);
  wire logic advanced = wdType != WD_SIMPLE;
  wire logic windowSel = cfg[CFG_WINDOW_BIT];
  wire logic isLastPart = partIdx == scw_last_part(wdType);

  // decided once the command byte is in, so the low reply byte can follow
  wire logic lastRefreshFrame = rx[7:0] == CMD_REFRESH && mode == MODE_NORMAL
                                && advanced && isLastPart;
  wire logic [7:0] replyLow = lastRefreshFrame ? lfsr : randomChallengeCode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt <= 5'h00;
      rx <= 16'h0000;
      tx <= 16'h0000;
      nextChal <= CHAL_SEED;
    end else if (csFall) begin
      bitCnt <= 5'h00;
      tx <= {4'h0, mode, randomChallengeCode};
    end else if (sclkRise) begin
      rx <= {rx[14:0], mosiS};
      bitCnt <= bitCnt + 5'h01;
    end else if (sclkFall && bitCnt == HALF_FRAME_BITS) begin
      tx <= {replyLow, 8'h00};
      nextChal <= lfsr;
    end else if (sclkFall) begin
      tx <= {tx[14:0], 1'b0};
    end
  end

  assign spi.miso = tx[15];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= CHAL_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // period and limits
  logic [CNT_W-1:0] periodLen;
  logic [CNT_W-1:0] curLimit;
  assign periodLen = CNT_W'((32'(periodCode) + 32'd1) * WD_UNIT);
  assign curLimit = (mode == MODE_NREQ && !nreqShort) ? CNT_W'(NREQ_TIMEOUT) : periodLen;

  wire logic periodEnd = periodCnt >= curLimit - 1'b1;
  wire logic inWindow = periodCnt >= {1'b0, periodLen[CNT_W-1:1]};
  wire logic [CNT_W-1:0] intLimit = {periodLen[CNT_W-2:0], 1'b0};
  wire logic intLate = cfg[CFG_INTCHK_BIT] && intPending && intAge >= intLimit - 1'b1;

  wire logic isRefresh = frameDone && cmd == CMD_REFRESH;
  wire logic nreqRefresh = isRefresh && dat == 8'h00
                           && (mode == MODE_INIT || mode == MODE_NREQ);
  // timeout type needs no window; last partial must land in window
  wire logic refreshOk = dat == scw_part_byte(randomChallengeCode, wdType, partIdx)
                         && (!isLastPart || !windowSel || inWindow);
  wire logic normalFail = mode == MODE_NORMAL
                          && ((isRefresh && !refreshOk)
                              || (!isRefresh && (periodEnd || intLate)));
  wire logic nreqFail = mode == MODE_NREQ && periodEnd && !nreqRefresh;
  wire logic wdFail = normalFail || nreqFail;
  wire logic goReset = wdFail && !dbgS;
  wire logic intRead = frameDone && cmd == CMD_INT_READ;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_INIT;
      periodCnt <= '0;
      partIdx <= 2'h0;
      resetHold <= '0;
      wdResetN <= 1'b1;
      randomChallengeCode <= CHAL_SEED;
    end else if (batS) begin
      mode <= MODE_INIT;
      periodCnt <= '0;
      partIdx <= 2'h0;
      wdResetN <= 1'b1;
    end else if (nreqRefresh) begin
      mode <= MODE_NORMAL;
      periodCnt <= '0;
      partIdx <= 2'h0;
    end else if (goReset) begin
      mode <= MODE_RESET;
      resetHold <= CNT_W'(RESET_HOLD - 1);
      wdResetN <= 1'b0;
      periodCnt <= '0;
      partIdx <= 2'h0;
    end else begin
      case (mode)
        MODE_NREQ, MODE_NORMAL: begin
          if (wdFail) begin
            // debug: restart silently
            periodCnt <= '0;
            partIdx <= 2'h0;
          end else if (isRefresh && mode == MODE_NORMAL && isLastPart) begin
            periodCnt <= '0;
            partIdx <= 2'h0;
            if (advanced) begin
              randomChallengeCode <= nextChal;
            end
          end else if (isRefresh && mode == MODE_NORMAL) begin
            partIdx <= partIdx + 2'h1;
            periodCnt <= periodCnt + 1'b1;
          end else begin
            periodCnt <= periodCnt + 1'b1;
          end
        end
        MODE_RESET: begin
          if (resetHold == '0) begin
            mode <= MODE_NREQ;
            wdResetN <= 1'b1;
            periodCnt <= '0;
          end else begin
            resetHold <= resetHold - 1'b1;
          end
        end
        MODE_INIT: begin
          periodCnt <= '0;
        end
        default: begin
          mode <= MODE_INIT;
        end
      endcase
    end
  end

  // configuration writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
      periodCode <= TIM_RESET;
      nreqShort <= 1'b0;
    end else if (batS) begin
      cfg <= CFG_RESET;
      periodCode <= TIM_RESET;
      nreqShort <= 1'b0;
    end else begin
      if (frameDone && cmd == CMD_INIT_WD && mode == MODE_INIT) begin
        cfg <= dat;
      end
      if (frameDone && cmd == CMD_TIMER && mode != MODE_RESET) begin
        periodCode <= dat[TIM_CODE_MSB:0];
        nreqShort <= dat[TIM_SHORT_BIT];
      end
      if (goReset) begin
        nreqShort <= 1'b0;
      end
    end
  end

  // interrupt pulse and read-back monitor; a new event beats a read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intPending <= 1'b0;
      intAge <= '0;
    end else if (eventIn) begin
      intPending <= 1'b1;
      intAge <= '0;
    end else if (intRead || goReset) begin
      intPending <= 1'b0;
      intAge <= '0;
    end else if (intPending) begin
      intAge <= intAge + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intPulseCnt <= 4'h0;
      intN <= 1'b1;
    end else if (eventIn) begin
      intPulseCnt <= INT_PULSE_CYC - 4'h1;
      intN <= 1'b0;
    end else if (intPulseCnt != 4'h0) begin
      intPulseCnt <= intPulseCnt - 4'h1;
    end else begin
      intN <= 1'b1;
    end
  end

  assign spi.intN = intN;

  // strap caught once the synchroniser has filled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bootCnt <= 2'h0;
      canSupplyRegulator <= 1'b0;
    end else if (bootCnt != BOOT_DONE) begin
      bootCnt <= bootCnt + 2'h1;
      if (bootCnt + 2'h1 == BOOT_DONE) begin
        canSupplyRegulator <= dbgS;
      end
    end else if (frameDone && cmd == CMD_CAN_REG) begin
      canSupplyRegulator <= dat[CAN_EN_BIT];
    end
  end
endmodule : scw_device

// file: logic/scw_host.sv
// host end: serial master making its own link clock, forms refresh frames
// assumes user logic supplies the watchdog type and window timing it configured
`timescale 1ns/1ps
module scw_host
  import scw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  scw_if.host spi,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  input wire logic refreshReq,
  input scw_wdtype_t wdType,
  input wire logic windowSel,
  input wire logic windowOpen,
  output logic cmdTaken,
  output logic busy,
  output logic rspValid,
  output logic [15:0] rspWord,
  output logic [7:0] randomChallengeCode,
  output logic intSeen
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_SHIFT = 3'h2,
    H_GAP = 3'h4
  } scw_hstate_t;
  typedef enum logic [1:0] {
    K_USER = 2'h0,
    K_CHAL = 2'h1,
    K_REFRESH = 2'h2
  } scw_kind_t;

  scw_hstate_t state;
  scw_kind_t kind;
  logic [3:0] divCnt;
  logic [4:0] bits;
  logic [15:0] txSh;
  logic [15:0] rxSh;
  logic [15:0] sentWord;
  logic sclk;
  logic csN;
  logic mosi;
  logic [1:0] misoSy;
  logic [1:0] intSy;
  logic refreshPending;
  logic needChal;
  logic [1:0] partIdx;

  assign spi.sclk = sclk;
  assign spi.csN = csN;
  assign spi.mosi = mosi;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misoSy <= 2'h0;
      intSy <= 2'h3;
      intSeen <= 1'b0;
    end else begin
      misoSy <= {misoSy[0], spi.miso};
      intSy <= {intSy[0], spi.intN};
      intSeen <= ~intSy[1];
    end
  end

  wire logic adv = wdType != WD_SIMPLE;
  wire logic lastPart = partIdx == scw_last_part(wdType);
  // final (or only) refresh frame waits for the open window
  wire logic refreshGo = refreshPending
                         && (!lastPart || !windowSel || windowOpen);
  wire logic [15:0] refreshWord = {CMD_REFRESH,
                                   scw_part_byte(randomChallengeCode, wdType, partIdx)};
  wire logic userGo = cmdValid && !needChal && !refreshGo;
  wire logic [15:0] startWord = needChal ? {CMD_READ_CHAL, 8'h00}
                                : (refreshGo ? refreshWord : cmdWord);
  wire scw_kind_t startKind = needChal ? K_CHAL : (refreshGo ? K_REFRESH : K_USER);
  wire logic tick = divCnt == SCLK_HALF_CYC - 4'h1;
  wire logic frameEnd = state == H_SHIFT && tick && sclk && bits == FRAME_BITS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      kind <= K_USER;
      divCnt <= 4'h0;
      bits <= 5'h00;
      txSh <= 16'h0000;
      rxSh <= 16'h0000;
      sentWord <= 16'h0000;
      sclk <= 1'b0;
      csN <= 1'b1;
      mosi <= 1'b0;
      busy <= 1'b0;
      cmdTaken <= 1'b0;
    end else begin
      cmdTaken <= 1'b0;
      divCnt <= tick ? 4'h0 : divCnt + 4'h1;
      case (state)
        H_IDLE: begin
          divCnt <= 4'h0;
          if (needChal || refreshGo || cmdValid) begin
            state <= H_SHIFT;
            kind <= startKind;
            txSh <= startWord;
            sentWord <= startWord;
            mosi <= startWord[15];
            bits <= 5'h00;
            csN <= 1'b0;
            busy <= 1'b1;
            cmdTaken <= userGo;
          end
        end
        H_SHIFT: begin
          if (tick && !sclk) begin
            sclk <= 1'b1;
            rxSh <= {rxSh[14:0], misoSy[1]};
            bits <= bits + 5'h01;
          end else if (tick) begin
            sclk <= 1'b0;
            txSh <= {txSh[14:0], 1'b0};
            mosi <= txSh[14];
            if (bits == FRAME_BITS) begin
              csN <= 1'b1;
              state <= H_GAP;
            end
          end
        end
        H_GAP: begin
          if (tick) begin
            state <= H_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // answer bookkeeping and challenge tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid <= 1'b0;
      rspWord <= 16'h0000;
      randomChallengeCode <= 8'h00;
      needChal <= 1'b0;
      refreshPending <= 1'b0;
      partIdx <= 2'h0;
    end else begin
      rspValid <= frameEnd;
      if (refreshReq) begin
        refreshPending <= 1'b1;
      end
      if (frameEnd) begin
        rspWord <= rxSh;
        if (kind == K_CHAL) begin
          randomChallengeCode <= rxSh[7:0];
          needChal <= 1'b0;
        end else if (kind == K_USER && sentWord == {CMD_REFRESH, 8'h00} && adv) begin
          needChal <= 1'b1;
        end else if (kind == K_REFRESH && lastPart) begin
          if (adv) begin
            randomChallengeCode <= rxSh[7:0];
          end
          partIdx <= 2'h0;
          refreshPending <= refreshReq;
        end else if (kind == K_REFRESH) begin
          partIdx <= partIdx + 2'h1;
        end
      end
    end
  end
endmodule : scw_host

// file: verif/scw_properties.sv
// checker on the serial link joining the host and device ends
// assumes the 50 MHz clock and the host's 8-clk link half period
`timescale 1ns/1ps
module scw_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic intN
);
  logic [4:0] riseCnt;
  logic [15:0] mosiWord;
  logic [15:0] misoWord;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // words are kept after the frame so they can be judged at select release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      riseCnt <= 5'h00;
      mosiWord <= 16'h0000;
      misoWord <= 16'h0000;
    end else if (csN) begin
      riseCnt <= 5'h00;
    end else if ($rose(sclk)) begin
      riseCnt <= riseCnt + 5'h01;
      mosiWord <= {mosiWord[14:0], mosi};
      misoWord <= {misoWord[14:0], miso};
    end
  end

  a_idle_clock_low: assert property (csN |-> !sclk)
    else $error("link clock not low while deselected");
  a_frame_sixteen_bits: assert property ($rose(csN) |-> riseCnt == 5'h10)
    else $error("frame did not carry sixteen clock rises");
  a_sclk_half_period: assert property (!csN && $changed(sclk) |=> $stable(sclk)[*7])
    else $error("link clock half period shorter than eight cycles");
  a_first_rise_delay: assert property ($fell(csN) |-> !sclk[*7] ##[1:2] $rose(sclk))
    else $error("first link clock rise not in place after select");
  a_mosi_hold_high: assert property ($rose(sclk) |-> $stable(mosi)[*8])
    else $error("host data moved while link clock high");
  a_miso_hold_high: assert property ($rose(sclk) |-> $stable(miso)[*8])
    else $error("device data moved while link clock high");
  a_select_gap: assert property ($rose(csN) |-> csN[*8])
    else $error("select gap between frames too short");
  a_int_pulse_width: assert property ($fell(intN) |-> !intN[*8] ##1 intN)
    else $error("interrupt pulse not eight cycles long");
  a_reply_mode_onehot: assert property (
    $rose(csN) |-> misoWord[15:12] == 4'h0 && $onehot(misoWord[11:8]))
    else $error("reply high byte does not carry the mode");

  c_refresh_frame: cover property ($rose(csN) && mosiWord[15:8] == 8'h5A);
  c_challenge_read: cover property ($rose(csN) && mosiWord == 16'h1B00);
  c_int_pulse: cover property ($fell(intN));
endmodule : scw_properties

// file: verif/spi_challenge_watchdog_bench.sv
// bench joining host and device ends through the link interface
// assumes shortened watchdog counts; the bench plays the host's user logic
`timescale 1ns/1ps
module spi_challenge_watchdog_bench;
  import scw_pkg::*;
  localparam int UNIT = 200;
  // timer code 7: period long enough to hold several frames
  localparam int PERIOD = 8 * UNIT;
  localparam int LIMIT = 60000;
  logic clk, rst_n, debugSelectPin, batteryFail, eventIn, cmdValid, refreshReq;
  logic windowSel, windowOpen, cmdTaken, busy, rspValid, intSeen, wdResetN;
  logic canSupplyRegulator;
  logic [15:0] cmdWord, rspWord;
  logic [7:0] hostChal, devChal, oldChal;
  scw_wdtype_t wdType;
  scw_mode_t mode;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int resetCycles = 0;
  int seen;

  scw_if link();
  scw_device #(.WD_UNIT(UNIT), .NREQ_TIMEOUT(2000), .RESET_HOLD(20)) u_scw_device (
    .clk(clk), .rst_n(rst_n), .spi(link), .debugSelectPin(debugSelectPin),
    .batteryFail(batteryFail), .eventIn(eventIn), .mode(mode), .wdResetN(wdResetN),
    .canSupplyRegulator(canSupplyRegulator), .randomChallengeCode(devChal));
  scw_host u_scw_host (
    .clk(clk), .rst_n(rst_n), .spi(link), .cmdValid(cmdValid), .cmdWord(cmdWord),
    .refreshReq(refreshReq), .wdType(wdType), .windowSel(windowSel),
    .windowOpen(windowOpen), .cmdTaken(cmdTaken), .busy(busy), .rspValid(rspValid),
    .rspWord(rspWord), .randomChallengeCode(hostChal), .intSeen(intSeen));
  scw_properties u_scw_properties (
    .clk(clk), .rst_n(rst_n), .sclk(link.sclk), .csN(link.csN), .mosi(link.mosi),
    .miso(link.miso), .intN(link.intN));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (mode === MODE_RESET) resetCycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_frame();
    int n;
    n = 0;
    while (rspValid !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
  endtask : wait_frame

  // request held until the host shows it was taken
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    cmdWord = w;
    cmdValid = 1'b1;
    tick(1);
    while (cmdTaken !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    cmdValid = 1'b0;
    wait_frame();
  endtask : send

  task automatic refresh();
    int parts;
    parts = (wdType == WD_ADV2) ? 2 : (wdType == WD_ADV4) ? 4 : 1;
    refreshReq = 1'b1;
    tick(1);
    refreshReq = 1'b0;
    repeat (parts) wait_frame();
  endtask : refresh

  task automatic expect_mode(input scw_mode_t m, input int limit);
    int n;
    n = 0;
    while (mode !== m && n < limit) begin
      tick(1);
      n++;
    end
    check("mode", {12'h000, m}, {12'h000, mode});
  endtask : expect_mode

  task automatic enter(input logic [7:0] cfg);
    batteryFail = 1'b1;
    tick(2);
    batteryFail = 1'b0;
    expect_mode(MODE_INIT, 10);
    wdType = scw_wdtype_t'(cfg[3:2]);
    windowSel = cfg[1];
    send({CMD_INIT_WD, cfg});
    send({CMD_TIMER, 8'h07});
    send(16'h5A00);
    if (wdType != WD_SIMPLE) wait_frame();
    expect_mode(MODE_NORMAL, 10);
    // simple type reads no challenge; last reply is the 0x5A00 frame sent in init
    if (wdType != WD_SIMPLE) begin
      check("challenge read", {8'h00, devChal}, {8'h00, hostChal});
      check("reply word", {4'h0, MODE_NORMAL, devChal}, rspWord);
    end else begin
      check("reply word", {4'h0, MODE_INIT, devChal}, rspWord);
    end
  endtask : enter

  task automatic t_reset();
    check("mode", {12'h000, MODE_INIT}, {12'h000, mode});
    check("wd reset", 16'h0001, {15'h0000, wdResetN});
    check("can regulator", 16'h0000, {15'h0000, canSupplyRegulator});
    check("select idle", 16'h0001, {15'h0000, link.csN});
  endtask : t_reset

  task automatic t_simple();
    enter(8'h00);
    seen = resetCycles;
    refresh();
    tick(PERIOD / 2);
    refresh();
    check("reset cycles", seen[15:0], resetCycles[15:0]);
    send(16'h5A01);
    expect_mode(MODE_RESET, 10);
    check("wd reset", 16'h0000, {15'h0000, wdResetN});
    expect_mode(MODE_NREQ, 40);
    send(16'h5A00);
    expect_mode(MODE_NORMAL, 10);
    send({CMD_TIMER, 8'h00});
    expect_mode(MODE_RESET, 600);
  endtask : t_simple

  task automatic t_adv();
    for (int t = 1; t < 4; t++) begin
      enter({4'h0, t[1:0], 2'b00});
      repeat (2) begin
        oldChal = devChal;
        refresh();
        expect_mode(MODE_NORMAL, 10);
        check("host challenge", {8'h00, devChal}, {8'h00, hostChal});
        check("challenge moved", 16'h0001, {15'h0000, devChal !== oldChal});
      end
      send({CMD_REFRESH, (t == 1) ? devChal : (t == 2) ? 8'h0F : 8'h3F});
      expect_mode(MODE_RESET, 10);
    end
  endtask : t_adv

  task automatic t_window();
    enter(8'h06);
    // claim the window open too soon to provoke an early refresh
    windowOpen = 1'b1;
    refresh();
    expect_mode(MODE_RESET, 10);
    expect_mode(MODE_NREQ, 40);
    send(16'h5A00);
    wait_frame();
    windowOpen = 1'b0;
    tick(PERIOD / 2 + 100);
    windowOpen = 1'b1;
    refresh();
    expect_mode(MODE_NORMAL, 10);
    windowOpen = 1'b0;
  endtask : t_window

  task automatic t_int();
    enter(8'h80);
    for (int k = 0; k < 2; k++) begin
      seen = resetCycles;
      eventIn = 1'b1;
      tick(1);
      eventIn = 1'b0;
      tick(5);
      check("interrupt seen", 16'h0001, {15'h0000, intSeen});
      if (k == 0) send({CMD_INT_READ, 8'h00});
      repeat (6) begin
        refresh();
        tick(300);
      end
      check("int check reset", {15'h0000, k[0]}, {15'h0000, resetCycles != seen});
    end
  endtask : t_int

  task automatic t_debug();
    debugSelectPin = 1'b1;
    tick(4);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(4);
    check("can regulator", 16'h0001, {15'h0000, canSupplyRegulator});
    send({CMD_CAN_REG, 8'h00});
    check("can regulator", 16'h0000, {15'h0000, canSupplyRegulator});
    enter(8'h00);
    seen = resetCycles;
    send(16'h5A01);
    tick(3 * PERIOD);
    check("debug reset", seen[15:0], resetCycles[15:0]);
    expect_mode(MODE_NORMAL, 1);
  endtask : t_debug

  initial begin
    rst_n = 1'b0;
    debugSelectPin = 1'b0;
    batteryFail = 1'b0;
    eventIn = 1'b0;
    cmdValid = 1'b0;
    cmdWord = 16'h0000;
    refreshReq = 1'b0;
    wdType = WD_SIMPLE;
    windowSel = 1'b0;
    windowOpen = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(4);
    t_reset();
    t_simple();
    t_adv();
    t_window();
    t_int();
    t_debug();
    end_of_test();
  end
endmodule : spi_challenge_watchdog_bench
